/* File: rtl/ubw_pkg.sv */
// Package for the break wake-up block: register map, fields, reset values, states
`default_nettype none
package ubw_pkg;

  // Clock
  localparam int unsigned CLK_PERIOD_NS = 40;

  // Register byte offsets
  localparam logic [7:0] MODE_OFF       = 8'h00;
  localparam logic [7:0] STATCTL_OFF    = 8'h04;
  localparam logic [7:0] INT_STATUS_OFF = 8'h08;
  localparam logic [7:0] INT_MASK_OFF   = 8'h0c;
  localparam logic [7:0] LINE_STATE_OFF = 8'h10;

  // Mode register fields
  localparam int unsigned MODE_ENABLE_BIT = 15;
  localparam int unsigned MODE_WAKE_BIT   = 7;
  localparam int unsigned MODE_LOOP_BIT   = 6;

  // Status and control register fields
  localparam int unsigned THRESH_LSB   = 6;
  localparam int unsigned THRESH_WIDTH = 2;
  localparam int unsigned RX_IDLE_BIT  = 0;

  // Interrupt status and mask layout
  localparam int unsigned INT_WIDTH      = 2;
  localparam int unsigned INT_RXEVT_BIT  = 0;
  localparam int unsigned INT_WDONE_BIT  = 1;

  // Line state register fields
  localparam int unsigned LS_LEVEL_BIT = 0;
  localparam int unsigned LS_STATE_LSB = 1;

  // Reset values
  localparam logic [15:0]             MODE_RST       = 16'h0000;
  localparam logic [THRESH_WIDTH-1:0] THRESH_RST     = 2'h0;
  localparam logic [INT_WIDTH-1:0]    INT_STATUS_RST = 2'h0;
  localparam logic [INT_WIDTH-1:0]    INT_MASK_RST   = 2'h0;

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    UBW_IDLE,
    UBW_ARMED,
    UBW_BREAK_LOW
  } ubw_state_t;

endpackage
`default_nettype wire

/* File: rtl/ubw_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ubw_sync
  import ubw_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk,       // System clock
  input  wire logic rst_n,     // Asynchronous reset, active low
  input  wire logic async_in,  // Raw pin level
  output var  logic sync_out   // Filtered level
);

  logic [SYNC_STAGES-1:0] stage_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= {SYNC_STAGES{RESET_LEVEL}};
    end else begin
      stage_reg <= {stage_reg[SYNC_STAGES-2:0], async_in};
    end
  end

  // First stage feeds only the second; output moves when stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= RESET_LEVEL;
    end else if (stage_reg[1] == stage_reg[2]) begin
      sync_out <= stage_reg[2];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/ubw_top.sv */
// Break wake-up detector for a serial receiver, with APB register file
//
// Contract
// - While armed, ordinary reception is suspended
// - Falling edge while armed is wake event
// - Wake event sets receive event flag
// - Edge watch only works with loopback cleared
// - Watch works clocked and with clock stopped
// - Next rising edge clears arm, resumes reception
// - Threshold field never affects wake flag
// - Enabled flag brings system out of sleep
// - Device reset restores all reset values
// - Power-on reset restores all reset values
// - Watchdog reset leaves registers untouched
// - No wake request while module disabled
// - Receive enable gates flag onto interrupt
`timescale 1ns/1ps
`default_nettype none
module ubw_top
  import ubw_pkg::*;
(
  input  wire logic        pclk,           // APB clock, 25 MHz
  input  wire logic        presetn,        // Device or power-on reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output var  logic [31:0] prdata,         // APB read data
  output var  logic        pready,         // APB ready
  output var  logic        pslverr,        // APB error, unmapped address
  input  wire logic        serial_in_pin,  // Serial receive pin
  input  wire logic        sleep_mode,     // System clock is being stopped
  input  wire logic        rx_line_idle,   // Receiver has no character in progress
  output var  logic        receiver_run,   // Ordinary reception allowed
  output var  logic        irq,            // Level interrupt
  output var  logic        wake_request    // Request to leave sleep
);

  logic [15:0]             mode_reg;
  logic [THRESH_WIDTH-1:0] receive_event_threshold_reg;
  logic [INT_WIDTH-1:0]    int_status_reg;
  logic [INT_WIDTH-1:0]    int_mask_reg;
  ubw_state_t              state_reg;
  ubw_state_t              state_next;
  logic                    level_prev_reg;
  logic                    serial_level;
  logic                    sleep_edge_level;
  logic                    sleep_edge_ack_reg;
  logic                    sleep_edge_reg;
  logic                    sleep_edge_clr;
  logic                    wake_event;
  logic                    wake_done;
  logic                    access_done;
  logic                    wr_en;
  logic                    addr_hit;
  logic [31:0]             rd_value;

  wire logic module_enable   = mode_reg[MODE_ENABLE_BIT];
  wire logic wake_arm        = mode_reg[MODE_WAKE_BIT];
  wire logic loopback_select = mode_reg[MODE_LOOP_BIT];
  // Armed watch needs module on and loopback off
  wire logic watch_live      = wake_arm & module_enable & ~loopback_select;

  wire logic [INT_WIDTH-1:0] receive_event_flag   = int_status_reg;
  wire logic [INT_WIDTH-1:0] receive_event_enable = int_mask_reg;

  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  // Serial input path in the running clock domain
  ubw_sync #(
    .RESET_LEVEL (1'b1)
  ) u_line_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in (serial_in_pin),
    .sync_out (serial_level)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_prev_reg <= 1'b1;
    end else begin
      level_prev_reg <= serial_level;
    end
  end

  // Stopped-clock capture: the pin edge itself clocks this flop.
  // Cleared by reset or by the clocked side once it has taken the event.
  assign sleep_edge_clr = ~presetn | sleep_edge_ack_reg;

  always_ff @(negedge serial_in_pin or posedge sleep_edge_clr) begin
    if (sleep_edge_clr) begin
      sleep_edge_reg <= 1'b0;
    end else if (watch_live && sleep_mode) begin
      sleep_edge_reg <= 1'b1;
    end
  end

  ubw_sync #(
    .RESET_LEVEL (1'b0)
  ) u_edge_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in (sleep_edge_reg),
    .sync_out (sleep_edge_level)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_edge_ack_reg <= 1'b0;
    end else begin
      sleep_edge_ack_reg <= sleep_edge_level;
    end
  end

  // Wake sequencer
  always_comb begin
    state_next = state_reg;
    wake_event = 1'b0;
    wake_done  = 1'b0;
    unique case (state_reg)
      UBW_IDLE: begin
        if (watch_live) begin
          state_next = UBW_ARMED;
        end
      end
      UBW_ARMED: begin
        if (!watch_live) begin
          state_next = UBW_IDLE;
        end else if ((level_prev_reg && !serial_level) || sleep_edge_level) begin
          wake_event = 1'b1;
          state_next = UBW_BREAK_LOW;
        end
      end
      UBW_BREAK_LOW: begin
        // Arm dropped by software mid-break: abandon quietly
        if (!wake_arm) begin
          state_next = UBW_IDLE;
        end else if (!level_prev_reg && serial_level) begin
          wake_done  = 1'b1;
          state_next = UBW_IDLE;
        end
      end
    endcase
  end

  // Registers reset only on presetn; a watchdog reset never reaches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= UBW_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // APB: one wait state, write takes effect on the edge where pready is high
  assign access_done = psel & penable & pready;
  assign wr_en       = access_done & pwrite;
  assign addr_hit    = addr_is(paddr, MODE_OFF) | addr_is(paddr, STATCTL_OFF) |
                       addr_is(paddr, INT_STATUS_OFF) | addr_is(paddr, INT_MASK_OFF) |
                       addr_is(paddr, LINE_STATE_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_hit;
    end
  end

  // Mode register; hardware clear of the arm bit beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_RST;
    end else begin
      if (wr_en && addr_is(paddr, MODE_OFF)) begin
        mode_reg <= pwdata[15:0];
      end
      if (wake_done) begin
        mode_reg[MODE_WAKE_BIT] <= 1'b0;
      end
    end
  end

  // Threshold is stored for the receiver only; wake logic never looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_event_threshold_reg <= THRESH_RST;
    end else if (wr_en && addr_is(paddr, STATCTL_OFF)) begin
      receive_event_threshold_reg <= pwdata[THRESH_LSB +: THRESH_WIDTH];
    end
  end

  // Sticky event bits, write one to clear, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= INT_STATUS_RST;
    end else begin
      if (wr_en && addr_is(paddr, INT_STATUS_OFF)) begin
        int_status_reg <= int_status_reg & ~pwdata[INT_WIDTH-1:0];
      end
      if (wake_event) begin
        int_status_reg[INT_RXEVT_BIT] <= 1'b1;
      end
      if (wake_done) begin
        int_status_reg[INT_WDONE_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_reg <= INT_MASK_RST;
    end else if (wr_en && addr_is(paddr, INT_MASK_OFF)) begin
      int_mask_reg <= pwdata[INT_WIDTH-1:0];
    end
  end

  // Read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (1'b1)
      addr_is(paddr, MODE_OFF): begin
        rd_value[15:0] = mode_reg;
      end
      addr_is(paddr, STATCTL_OFF): begin
        rd_value[THRESH_LSB +: THRESH_WIDTH] = receive_event_threshold_reg;
        rd_value[RX_IDLE_BIT]                = rx_line_idle;
      end
      addr_is(paddr, INT_STATUS_OFF): begin
        rd_value[INT_WIDTH-1:0] = int_status_reg;
      end
      addr_is(paddr, INT_MASK_OFF): begin
        rd_value[INT_WIDTH-1:0] = int_mask_reg;
      end
      addr_is(paddr, LINE_STATE_OFF): begin
        rd_value[LS_LEVEL_BIT]       = serial_level;
        rd_value[LS_STATE_LSB +: 2]  = state_reg;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= rd_value;
    end
  end

  // Outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receiver_run <= 1'b0;
    end else begin
      receiver_run <= module_enable & ~wake_arm;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(receive_event_flag & receive_event_enable);
    end
  end

  // Wake request is a pclk flop; the stopped-clock capture reaches it through u_edge_sync only once pclk runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= module_enable & receive_event_enable[INT_RXEVT_BIT] &
                      (receive_event_flag[INT_RXEVT_BIT] | wake_event);
    end
  end

endmodule
`default_nettype wire

/* File: verification/ubw_sva.sv */
// Port assertions for the break wake-up block
`timescale 1ns/1ps
`default_nettype none
module ubw_sva
  import ubw_pkg::*;
(
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Reset
  input wire logic        psel,          // Select
  input wire logic        penable,       // Enable
  input wire logic        pwrite,        // Direction
  input wire logic [7:0]  paddr,         // Address
  input wire logic [31:0] pwdata,        // Write data
  input wire logic        pready,        // Ready
  input wire logic        pslverr,       // Error
  input wire logic        serial_in_pin, // Serial pin
  input wire logic        sleep_mode,    // Sleep
  input wire logic        receiver_run,  // Reception allowed
  input wire logic        irq,           // Interrupt
  input wire logic        wake_request   // Wake request
);
  logic       en_m;
  logic       loop_m;
  logic [1:0] mask_m;
  logic       wr_acc;
  assign wr_acc = psel && penable && pready && pwrite;
  // Shadow of software writes; hardware only clears the arm bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_m <= 1'b0;
      loop_m <= 1'b0;
      mask_m <= 2'h0;
    end else if (wr_acc && paddr == MODE_OFF) begin
      en_m <= pwdata[MODE_ENABLE_BIT];
      loop_m <= pwdata[MODE_LOOP_BIT];
    end else if (wr_acc && paddr == INT_MASK_OFF) begin
      mask_m <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_map_a: assert property (pready |-> pslverr == (paddr > LINE_STATE_OFF || paddr[1:0] != 2'h0))
    else $error("error flag wrong for address");
  irq_mask_a: assert property (mask_m == 2'h0 && $past(mask_m) == 2'h0 |-> !irq)
    else $error("interrupt with all masked");
  wake_mask_a: assert property (!mask_m[0] && !$past(mask_m[0]) |-> !wake_request)
    else $error("wake request with event masked");
  wake_dis_a: assert property (!en_m && !$past(en_m) |-> !wake_request)
    else $error("wake request while disabled");
  arm_stop_a: assert property (wr_acc && paddr == MODE_OFF && pwdata[15] && pwdata[7]
    |-> ##2 !receiver_run)
    else $error("reception not suspended when armed");
  sync_lag_a: assert property (!psel && !sleep_mode && $fell(serial_in_pin)
    |=> $stable(wake_request))
    else $error("pin reached logic unsynchronised");
  wake_time_a: assert property (en_m && !loop_m && mask_m[0] && !receiver_run
    && !sleep_mode && $fell(serial_in_pin) |-> ##[1:8] wake_request)
    else $error("no wake request after falling edge");
endmodule
bind ubw_top ubw_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .serial_in_pin(serial_in_pin), .sleep_mode(sleep_mode), .receiver_run(receiver_run),
  .irq(irq), .wake_request(wake_request));
`default_nettype wire

/* File: verification/ubw_node.sv */
// Remote bus node driving break characters onto the serial line
`timescale 1ns/1ps
`default_nettype none
module ubw_node (
  input  wire logic clk,  // Bench clock
  output var  logic line  // Serial line, idle high
);
  initial line = 1'b1;
  // Caller keeps the low phase long enough for the receiver to wake
  task automatic drive(input logic v);
    @(posedge clk);
    line <= v;
  endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the break wake-up block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ubw_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, serial_in_pin, sleep_mode = 1'b0, rx_line_idle = 1'b1;
  logic receiver_run, irq, wake_request;
  int err_count = 0, n_tests = 0, cyc = 0;
  always #20 pclk = ~pclk;
  ubw_node node (.clk(pclk), .line(serial_in_pin));
  ubw_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(serial_in_pin), .sleep_mode(sleep_mode),
    .rx_line_idle(rx_line_idle), .receiver_run(receiver_run), .irq(irq),
    .wake_request(wake_request));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic break_char(input logic [31:0] mode, input logic [1:0] mask);
    apb(1'b1, INT_MASK_OFF, {30'h0, mask});
    apb(1'b1, MODE_OFF, mode);
    repeat (3) @(posedge pclk);
    node.drive(1'b0);
    repeat (12) @(posedge pclk);
  endtask
  task automatic t_regs;
    apb(1'b1, STATCTL_OFF, 32'hc0);
    apb(1'b1, INT_MASK_OFF, 32'h3);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MODE_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, STATCTL_OFF, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, INT_MASK_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(er, 1'b1);
  endtask
  task automatic t_wake;
    apb(1'b1, STATCTL_OFF, 32'hc0);
    break_char(32'h8080, 2'h3);
    chk(receiver_run, 1'b0);
    chk(wake_request, 1'b1);
    chk(irq, 1'b1);
    apb(1'b0, INT_STATUS_OFF, 32'h0);
    chk(rd[0], 1'b1);
    node.drive(1'b1);
    repeat (12) @(posedge pclk);
    chk(receiver_run, 1'b1);
    apb(1'b0, MODE_OFF, 32'h0);
    chk(rd, 32'h8000);
    apb(1'b1, INT_STATUS_OFF, 32'h3);
    apb(1'b0, INT_STATUS_OFF, 32'h0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
  endtask
  task automatic t_gate;
    break_char(32'h8080, 2'h2);
    chk(wake_request, 1'b0);
    node.drive(1'b1);
    repeat (12) @(posedge pclk);
    apb(1'b1, INT_STATUS_OFF, 32'h3);
    break_char(32'h0080, 2'h3);
    chk(wake_request, 1'b0);
    apb(1'b0, INT_STATUS_OFF, 32'h0);
    chk(rd, 32'h0);
    node.drive(1'b1);
    repeat (12) @(posedge pclk);
    // Loopback selected: armed watch must stay deaf
    break_char(32'h80c0, 2'h3);
    chk(wake_request, 1'b0);
    chk(receiver_run, 1'b0);
    apb(1'b0, INT_STATUS_OFF, 32'h0);
    chk(rd, 32'h0);
    node.drive(1'b1);
  endtask
  task automatic t_sleep;
    sleep_mode <= 1'b1;
    break_char(32'h8080, 2'h1);
    chk(wake_request, 1'b1);
    sleep_mode <= 1'b0;
    node.drive(1'b1);
    repeat (12) @(posedge pclk);
    chk(receiver_run, 1'b1);
  endtask
  task automatic end_of_test;
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Run takes about 250 cycles; generous ceiling against a hang
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_wake();
    t_gate();
    t_sleep();
    end_of_test();
  end
endmodule
`default_nettype wire
